// file: hw/logic_bist_engine.sv
`timescale 1ns/1ps
module logic_bist_engine
	import sensor_cfg_pkg::*;
#(
	parameter int CYCLES = LOGIC_BUILTIN_TEST_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic start,
	output logic busy,
	output logic done,
	output logic [30:0] signature
);

	bist_state_type q;
	bist_state_type d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (!q.busy) begin
			if (start) begin
				d.busy = 1'b1;
				d.cnt = '0;
				d.lfsr = LFSR_SEED;
				d.chains = '0;
				d.misr = '0;
			end
		end else begin
			// Pattern source, chains shifted in parallel, MISR compaction
			d.lfsr = {q.lfsr[29:0], q.lfsr[30] ^ q.lfsr[27]};
			d.chains = q.lfsr ^ {q.chains[0], q.chains[30:1]};
			d.misr = {q.misr[29:0], q.misr[30] ^ q.misr[27]} ^ q.chains;
			d.cnt = q.cnt + 22'h000001;
			if (q.cnt == 22'(CYCLES - 1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign busy = q.busy;
	assign done = q.done;
	assign signature = q.misr;

	chk_bist_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && start && !q.busy) |=> q.busy && q.lfsr == LFSR_SEED)
		else $error("bist did not start from seed");

endmodule

// file: hw/sensor_cfg_pkg.sv
package sensor_cfg_pkg;

	// Word addresses of the serial register space
	localparam logic [7:0] ADDR_CUSTOMER_WORD_TWO = 8'h17;
	localparam logic [7:0] ADDR_COMMON = 8'h1e;
	localparam logic [7:0] ADDR_CUSTOMER = 8'h1f;
	localparam logic [7:0] ADDR_LIN_FIRST = 8'h20;
	localparam logic [7:0] ADDR_LIN_LAST = 8'h2f;
	localparam logic [7:0] ADDR_ALIVE = 8'h80;

	// Field layout of common_config, bit 23 down to bit 0
	typedef struct packed {
		logic [3:0] lock;
		logic powerup_logic_bist;
		logic powerup_transducer_selftest;
		logic unlock_bypass_customer;
		logic lock_bypass_customer;
		logic reserved;
		logic customer_word_follows_policy;
		logic selftest_cmd_disable;
		logic hard_reset_cmd_disable;
		logic [5:0] high_field_threshold;
		logic [5:0] low_field_threshold;
	} common_cfg_type;

	// Factory values: high code 10 0101, low code 00 1101
	localparam logic [23:0] COMMON_RESET = 24'h00094d;
	localparam logic [23:0] CUSTOMER_RESET = 24'h000000;
	localparam logic [23:0] LIN_RESET = 24'h000000;
	localparam logic [23:0] COMMON_WRITE_MASK = 24'hff7fff;

	// Threshold code to gauss: shift by 5 is x32, shift by 4 is x16
	localparam int HIGH_THR_SHIFT = 5;
	localparam int LOW_THR_SHIFT = 4;

	localparam logic [3:0] LOCK_EEPROM = 4'hc;
	localparam logic [3:0] LOCK_ALL = 4'h3;

	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_HARD_RESET,
		CMD_SELFTEST
	} special_cmd_type;

	// Timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam longint ALIVE_UNIT_PS = 64'd8192000000;
	localparam int ALIVE_UNIT_CYCLES = int'(ALIVE_UNIT_PS / CLK_PERIOD_PS);
	localparam longint SELFTEST_PS = 64'd30000000000;
	localparam int SELFTEST_CYCLES = int'(SELFTEST_PS / CLK_PERIOD_PS);
	localparam int LOGIC_BUILTIN_TEST_CYCLES = int'(SELFTEST_PS / CLK_PERIOD_PS);
	localparam int WDOG_WINDOW_PS = 8192000;
	localparam int WDOG_WINDOW_CYCLES = WDOG_WINDOW_PS / CLK_PERIOD_PS;
	localparam logic [10:0] WDOG_LAST = 11'(WDOG_WINDOW_CYCLES - 1);
	localparam logic [7:0] WDOG_MIN_EDGES = 8'h30;
	localparam logic [7:0] WDOG_MAX_EDGES = 8'h50;

	localparam logic [30:0] LFSR_SEED = 31'h00000001;

	typedef struct packed {
		logic wr;
		logic rd;
		logic indirect;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic ack;
		logic refused;
		logic [31:0] rdata;
	} reg_rsp_type;

	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} selftest_state_type;

	typedef struct packed {
		common_cfg_type cfg;
		logic [23:0] customer;
		logic [15:0][23:0] lin;
		logic [31:0] alive;
		logic [21:0] unit_cnt;
		logic [5:0] step_cnt;
		logic ref_s1;
		logic ref_s2;
		logic ref_prev;
		logic [10:0] win_cnt;
		logic [7:0] edge_cnt;
		logic osc_fail;
		selftest_state_type st;
		logic [21:0] st_cnt;
		logic special_done;
		logic st_fail;
		logic pu_pending;
		logic bist_fail;
		logic hard_reset_pulse;
		logic customer_word_two_grant;
		reg_rsp_type rsp;
		logic high_flag;
		logic low_flag;
		logic [15:0] lin_angle;
	} core_state_type;

	typedef struct packed {
		logic busy;
		logic done;
		logic [21:0] cnt;
		logic [30:0] lfsr;
		logic [30:0] chains;
		logic [30:0] misr;
	} bist_state_type;

endpackage

// file: hw/sensor_config_diagnostics.sv
`timescale 1ns/1ps
// Operation
// - High field flag when field exceeds code x32 gauss; code zero disables
// - Hard reset command ignored while its disable bit is set
// - Self-test command refused while its disable bit is set
// - Follows-policy bit extends both bypasses from word 0x17 to 0x1f
// - Lock bypass keeps customer words writable under EEPROM lock
// - Unlock bypass lets customer words be written without unlock step
// - Power-up transducer self-test runs when its enable is set
// - Power-up logic BIST runs when its enable is set
// - Lock 1100 blocks EEPROM writes; 0011 also blocks indirect writes
// - 24-bit customer storage word with no effect on behaviour
// - Two signed 12-bit corrections per word, subtracted from angle
// - Thirty-two corrections across sixteen words, 30 and 31 in last
// - 32-bit alive counter from zero after reset, wraps on overflow
// - Alive counter steps every (cycle field + 1) x 8.192 ms
// - Extended read at 0x80 returns full 32-bit alive count
// - Watchdogs run when awake, stop in sleep, restart on wake
// - Count other oscillator's periods, flag count outside limits
// - Logic BIST: 31-bit LFSR feeds 31 chains, MISR signature
// - Logic BIST may run together with transducer self-test, about 30 ms
// - Self-test special command starts the transducer self-test
// - Done bit or running low ends test; fail bit flags failure
// - Low field flag when field below code x16 gauss; zero disables
// - Low-power cycle field (N + 1) x 8.192 ms sets alive rate
// - Scale bit 0 gives +-22.5 degrees, 1 gives +-45 degrees
module sensor_config_diagnostics
	import sensor_cfg_pkg::*;
#(
	parameter int ALIVE_UNIT_CYC = ALIVE_UNIT_CYCLES,
	parameter int SELFTEST_CYC = SELFTEST_CYCLES,
	parameter int LOGIC_BUILTIN_TEST_CYC = LOGIC_BUILTIN_TEST_CYCLES,
	parameter logic [30:0] LOGIC_BUILTIN_TEST_GOLDEN = 31'h00000000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input reg_req_type reg_req,
	output reg_rsp_type reg_rsp,
	input wire logic cmd_valid,
	input special_cmd_type cmd_code,
	input wire logic eeprom_unlocked,
	output logic customer_word_two_write_grant,
	output logic hard_reset_event,
	input wire logic [5:0] lpm_cycle_time,
	input wire logic [11:0] field_strength,
	output logic high_field_flag,
	output logic low_field_flag,
	input wire logic correction_scale_select,
	input wire logic [15:0] sensor_angle,
	output logic [15:0] linearized_angle,
	input wire logic sleep_mode,
	input wire logic osc_ref_clk,
	output logic osc_fail,
	input wire logic transducer_angle_ok,
	input wire logic selftest_fail_clear,
	output logic transducer_selftest_running,
	output logic special_done,
	output logic selftest_fail,
	output logic logic_builtin_test_busy,
	output logic bist_fail,
	output logic [30:0] bist_signature
);

	core_state_type q;
	core_state_type d;
	logic hr_take;
	logic st_cmd;
	logic st_start;
	logic bist_start;
	logic bist_done;
	logic wr_ok;
	logic [3:0] lin_word;
	logic [11:0] corr;
	logic [15:0] corr_ext;

	function automatic logic write_allowed(input logic [7:0] addr, input logic indirect,
		input common_cfg_type cfg, input logic unlocked);
		logic custom;
		logic ee_lock;
		logic ind_lock;
		custom = (addr == ADDR_CUSTOMER_WORD_TWO) ||
			((addr == ADDR_CUSTOMER) && cfg.customer_word_follows_policy);
		ee_lock = (cfg.lock == LOCK_EEPROM) || (cfg.lock == LOCK_ALL);
		ind_lock = (cfg.lock == LOCK_ALL);
		// Any other lock code blocks nothing; direct writes still need unlock or the unlock bypass
		if (indirect) begin
			write_allowed = !ind_lock;
		end else begin
			write_allowed = (unlocked || (custom && cfg.unlock_bypass_customer)) &&
				(!ee_lock || (custom && cfg.lock_bypass_customer));
		end
	endfunction

	function automatic logic is_lin(input logic [7:0] addr);
		is_lin = (addr >= ADDR_LIN_FIRST) && (addr <= ADDR_LIN_LAST);
	endfunction

	assign hr_take = cmd_valid && (cmd_code == CMD_HARD_RESET) &&
		!q.cfg.hard_reset_cmd_disable;
	assign st_cmd = cmd_valid && (cmd_code == CMD_SELFTEST) &&
		!q.cfg.selftest_cmd_disable;
	assign st_start = (q.st == ST_IDLE) && !hr_take &&
		(st_cmd || (q.pu_pending && q.cfg.powerup_transducer_selftest));
	// Independent of the transducer test, so both may overlap
	assign bist_start = q.pu_pending && q.cfg.powerup_logic_bist && !hr_take;
	assign wr_ok = write_allowed(reg_req.addr, reg_req.indirect, q.cfg, eeprom_unlocked);

	// Segment boundary lookup, two halves per word
	assign lin_word = sensor_angle[15:12];
	assign corr = sensor_angle[11] ? q.lin[lin_word][23:12] : q.lin[lin_word][11:0];
	assign corr_ext = {{4{corr[11]}}, corr};

	logic_bist_engine #(
		.CYCLES(LOGIC_BUILTIN_TEST_CYC)
	) u_bist (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(bist_start),
		.busy(logic_builtin_test_busy),
		.done(bist_done),
		.signature(bist_signature)
	);

	always_comb begin
		d = q;
		d.pu_pending = 1'b0;
		d.hard_reset_pulse = hr_take;
		d.customer_word_two_grant = 1'b0;
		d.rsp = '0;

		// Field comparators
		d.high_flag = (q.cfg.high_field_threshold != 6'h00) &&
			(field_strength > (12'(q.cfg.high_field_threshold) << HIGH_THR_SHIFT));
		d.low_flag = (q.cfg.low_field_threshold != 6'h00) &&
			(field_strength < (12'(q.cfg.low_field_threshold) << LOW_THR_SHIFT));

		// Correction subtracted at the selected scale
		d.lin_angle = sensor_angle -
			(correction_scale_select ? (corr_ext << 2) : (corr_ext << 1));

		// Register writes take priority over reads in the same cycle
		if (reg_req.wr) begin
			d.rsp.ack = 1'b1;
			d.rsp.refused = 1'b1;
			if (wr_ok) begin
				d.rsp.refused = 1'b0;
				if (reg_req.addr == ADDR_COMMON) begin
					d.cfg = common_cfg_type'(reg_req.wdata[23:0] & COMMON_WRITE_MASK);
				end else if (reg_req.addr == ADDR_CUSTOMER) begin
					d.customer = reg_req.wdata[23:0];
				end else if (is_lin(reg_req.addr)) begin
					d.lin[reg_req.addr[3:0]] = reg_req.wdata[23:0];
				end else if (reg_req.addr == ADDR_CUSTOMER_WORD_TWO) begin
					d.customer_word_two_grant = 1'b1;
				end else begin
					d.rsp.refused = 1'b1;
				end
			end
		end else if (reg_req.rd) begin
			d.rsp.ack = 1'b1;
			if (reg_req.addr == ADDR_COMMON) begin
				d.rsp.rdata = {8'h00, q.cfg};
			end else if (reg_req.addr == ADDR_CUSTOMER) begin
				d.rsp.rdata = {8'h00, q.customer};
			end else if (is_lin(reg_req.addr)) begin
				d.rsp.rdata = {8'h00, q.lin[reg_req.addr[3:0]]};
			end else if (reg_req.addr == ADDR_ALIVE) begin
				d.rsp.rdata = q.alive;
			end else begin
				d.rsp.refused = 1'b1;
			end
		end

		// Alive counter: unit tick of 8.192 ms, N + 1 units per step
		if (q.unit_cnt == 22'(ALIVE_UNIT_CYC - 1)) begin
			d.unit_cnt = '0;
			if (q.step_cnt >= lpm_cycle_time) begin
				d.step_cnt = '0;
				d.alive = q.alive + 32'h00000001;
			end else begin
				d.step_cnt = q.step_cnt + 6'h01;
			end
		end else begin
			d.unit_cnt = q.unit_cnt + 22'h000001;
		end

		// Oscillator cross
		d.ref_s1 = osc_ref_clk;
		d.ref_s2 = q.ref_s1;
		d.ref_prev = q.ref_s2;
		if (sleep_mode) begin
			d.win_cnt = '0;
			d.edge_cnt = '0;
		end else begin
			if (q.ref_s2 && !q.ref_prev && (q.edge_cnt != 8'hff)) begin
				d.edge_cnt = q.edge_cnt + 8'h01;
			end
			d.win_cnt = q.win_cnt + 11'h001;
			if (q.win_cnt == WDOG_LAST) begin
				d.win_cnt = '0;
				d.edge_cnt = '0;
				if ((q.edge_cnt < WDOG_MIN_EDGES) || (q.edge_cnt > WDOG_MAX_EDGES)) begin
					d.osc_fail = 1'b1;
				end
			end
		end

		// Transducer self-test sequence
		unique case (q.st)
			ST_IDLE: begin
				if (st_start) begin
					d.st = ST_RUN;
					d.st_cnt = '0;
					d.special_done = 1'b0;
				end
			end
			ST_RUN: begin
				d.st_cnt = q.st_cnt + 22'h000001;
				if (q.st_cnt == 22'(SELFTEST_CYC - 1)) begin
					d.st = ST_IDLE;
					d.special_done = 1'b1;
				end
			end
		endcase
		// Failure is sticky; a hit in the clearing cycle wins
		if (selftest_fail_clear) begin
			d.st_fail = 1'b0;
		end
		if ((q.st == ST_RUN) && !transducer_angle_ok) begin
			d.st_fail = 1'b1;
		end

		if (bist_done && (bist_signature != LOGIC_BUILTIN_TEST_GOLDEN)) begin
			d.bist_fail = 1'b1;
		end

		// Accepted hard reset restarts counters and power-up tests, except a BIST already running
		if (hr_take) begin
			d.alive = '0;
			d.unit_cnt = '0;
			d.step_cnt = '0;
			d.win_cnt = '0;
			d.edge_cnt = '0;
			d.osc_fail = 1'b0;
			d.st = ST_IDLE;
			d.special_done = 1'b0;
			d.bist_fail = 1'b0;
			d.pu_pending = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.cfg <= common_cfg_type'(COMMON_RESET);
			q.customer <= CUSTOMER_RESET;
			q.lin <= {16{LIN_RESET}};
			q.pu_pending <= 1'b1;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign reg_rsp = q.rsp;
	assign customer_word_two_write_grant = q.customer_word_two_grant;
	assign hard_reset_event = q.hard_reset_pulse;
	assign high_field_flag = q.high_flag;
	assign low_field_flag = q.low_flag;
	assign linearized_angle = q.lin_angle;
	assign osc_fail = q.osc_fail;
	assign transducer_selftest_running = (q.st == ST_RUN);
	assign special_done = q.special_done;
	assign selftest_fail = q.st_fail;
	assign bist_fail = q.bist_fail;

	chk_high_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && q.cfg.high_field_threshold == 6'h00) |=> !high_field_flag)
		else $error("high field flag set while disabled");
	chk_low_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && q.cfg.low_field_threshold == 6'h00) |=> !low_field_flag)
		else $error("low field flag set while disabled");
	chk_hard_reset_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && cmd_valid && cmd_code == CMD_HARD_RESET && q.cfg.hard_reset_cmd_disable)
		|=> !hard_reset_event)
		else $error("hard reset taken while disabled");
	chk_selftest_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && q.st == ST_IDLE && q.cfg.selftest_cmd_disable && !q.pu_pending)
		|=> !transducer_selftest_running)
		else $error("self-test started while command disabled");
	chk_lock_blocks_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && reg_req.wr && reg_req.indirect && q.cfg.lock == LOCK_ALL)
		|=> reg_rsp.ack && reg_rsp.refused)
		else $error("indirect write accepted under full lock");
	chk_alive_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_ALIVE)
		|=> reg_rsp.ack && reg_rsp.rdata == $past(q.alive))
		else $error("alive read returned wrong count");
	chk_alive_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !hr_take && q.unit_cnt != 22'(ALIVE_UNIT_CYC - 1))
		|=> q.alive == $past(q.alive))
		else $error("alive counter stepped between ticks");
	chk_fail_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && q.st == ST_RUN && !transducer_angle_ok) |=> selftest_fail)
		else $error("self-test failure not recorded");
	chk_run_length: assert property (@(posedge sys_clk)
		disable iff (!rst_n || hard_reset_event)
		$rose(transducer_selftest_running) |-> transducer_selftest_running [*8])
		else $error("self-test ended too early");
	chk_wdog_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && sleep_mode && !hr_take) |=> q.win_cnt == 11'h000 && !$rose(osc_fail))
		else $error("watchdog counting during sleep");

	cov_selftest_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(special_done));
	cov_hard_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
		hard_reset_event);
	cov_alive_step: cover property (@(posedge sys_clk) disable iff (!rst_n)
		q.alive != $past(q.alive));

endmodule

// file: tb/host_model.sv
`timescale 1ns/1ps
// Host side of the serial register path and the special command path
module host_model
	import sensor_cfg_pkg::*;
(
	input wire logic sys_clk,
	input reg_rsp_type reg_rsp,
	output reg_req_type reg_req,
	output logic cmd_valid,
	output special_cmd_type cmd_code
);
	initial begin
		reg_req = '0;
		cmd_valid = 1'b0;
		cmd_code = CMD_NONE;
	end

	// One request over one taking edge, then a bounded wait for the answer
	task automatic access(input logic is_wr, input logic ind, input logic [7:0] addr,
		input logic [31:0] wdata, output reg_rsp_type rsp);
		int i;
		@(posedge sys_clk);
		reg_req <= '{wr: is_wr, rd: !is_wr, indirect: ind, addr: addr, wdata: wdata};
		@(posedge sys_clk);
		// Released lines show no stale value
		reg_req <= '{wr: 1'b0, rd: 1'b0, indirect: !ind, addr: ~addr, wdata: ~wdata};
		rsp = '0;
		for (i = 0; i < 4; i++) begin
			#1;
			rsp = reg_rsp;
			if (rsp.ack === 1'b1) break;
			@(posedge sys_clk);
		end
	endtask

	// Special command, one cycle wide
	task automatic command(input special_cmd_type code);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_code <= CMD_NONE;
		#1;
	endtask
endmodule

// file: tb/sensor_config_diagnostics_tb_top.sv
`timescale 1ns/1ps
module sensor_config_diagnostics_tb_top
	import sensor_cfg_pkg::*;
;
	logic sys_clk, rst_n, clk_en, unl, scale, sleep_mode, osc_ref_clk, ref_run;
	logic angle_ok, fail_clear, cmd_valid, grant, hr_event, hi, lo, osc_fail;
	logic running, done, st_fail, bist_busy, bist_fail;
	logic [5:0] lpm;
	logic [11:0] field;
	logic [15:0] angle, lin_out;
	logic [30:0] sig;
	special_cmd_type cmd_code;
	reg_req_type reg_req;
	reg_rsp_type reg_rsp;
	int errors, check_count, cycles;

	always #4 sys_clk = ~sys_clk;
	always #64 if (ref_run) osc_ref_clk = ~osc_ref_clk;

	sensor_config_diagnostics #(.ALIVE_UNIT_CYC(10), .SELFTEST_CYC(20), .LOGIC_BUILTIN_TEST_CYC(20)) uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(reg_req),
		.reg_rsp(reg_rsp), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.eeprom_unlocked(unl), .customer_word_two_write_grant(grant), .hard_reset_event(hr_event),
		.lpm_cycle_time(lpm), .field_strength(field), .high_field_flag(hi),
		.low_field_flag(lo), .correction_scale_select(scale), .sensor_angle(angle),
		.linearized_angle(lin_out), .sleep_mode(sleep_mode), .osc_ref_clk(osc_ref_clk),
		.osc_fail(osc_fail), .transducer_angle_ok(angle_ok), .selftest_fail_clear(fail_clear),
		.transducer_selftest_running(running), .special_done(done), .selftest_fail(st_fail),
		.logic_builtin_test_busy(bist_busy), .bist_fail(bist_fail), .bist_signature(sig)
	);

	host_model host (
		.sys_clk(sys_clk), .reg_rsp(reg_rsp), .reg_req(reg_req),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("timeout after %0d cycles", cycles);
			end_of_test();
		end
	end

	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		reg_rsp_type q;
		host.access(1'b0, 1'b0, a, 32'h0, q);
		check("read_ack", 32'(q.ack), 32'h1);
		check("rdata", q.rdata, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_rsp_type q;
		host.access(1'b1, 1'b1, a, d, q);
	endtask

	// Fresh config, then one write attempt judged against the lock policy
	task automatic policy(input logic [23:0] cfg, input logic u, input logic ind,
		input logic [7:0] a, input logic refd);
		reg_rsp_type q;
		do_reset();
		unl <= u;
		wr(ADDR_COMMON, {8'h00, cfg});
		host.access(1'b1, ind, a, 32'h00a5a5a5, q);
		check("refused", 32'(q.refused), 32'(refd));
		if (a == ADDR_CUSTOMER_WORD_TWO) check("grant", 32'(grant), 32'(!refd));
		else rd_chk(a, refd ? 32'h0 : 32'h00a5a5a5);
		unl <= 1'b1;
	endtask

	task automatic flags(input logic [11:0] v, input logic h, input logic l);
		@(posedge sys_clk);
		field <= v;
		@(posedge sys_clk);
		#1;
		check("high_flag", 32'(hi), 32'(h));
		check("low_flag", 32'(lo), 32'(l));
	endtask

	task automatic lin(input logic [15:0] a, input logic s, input logic [15:0] exp);
		@(posedge sys_clk);
		angle <= a;
		scale <= s;
		@(posedge sys_clk);
		#1;
		check("linearized", 32'(lin_out), 32'(exp));
	endtask

	initial begin
		reg_rsp_type q;
		logic [31:0] a0;
		int n;
		sys_clk = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		unl = 1'b1;
		scale = 1'b0;
		sleep_mode = 1'b0;
		osc_ref_clk = 1'b0;
		ref_run = 1'b1;
		angle_ok = 1'b1;
		fail_clear = 1'b0;
		lpm = 6'h00;
		field = 12'h258;
		angle = 16'h0000;
		errors = 0;
		check_count = 0;
		cycles = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd_chk(ADDR_COMMON, 32'h0000094d);
		rd_chk(ADDR_CUSTOMER, 32'h0);
		rd_chk(ADDR_LIN_FIRST, 32'h0);
		rd_chk(ADDR_LIN_LAST, 32'h0);
		wr(ADDR_COMMON, 32'hff00ffff);
		rd_chk(ADDR_COMMON, 32'h00007fff);
		host.access(1'b0, 1'b0, 8'h40, 32'h0, q);
		check("unmapped", {31'h0, q.refused}, 32'h1);
		host.access(1'b1, 1'b1, ADDR_ALIVE, 32'h1, q);
		check("alive_write", {31'h0, q.refused}, 32'h1);
		$display("test registers done");
		policy(24'hc0094d, 1'b1, 1'b0, ADDR_CUSTOMER, 1'b1);
		policy(24'hc0094d, 1'b1, 1'b1, ADDR_CUSTOMER, 1'b0);
		policy(24'h30094d, 1'b1, 1'b1, ADDR_CUSTOMER, 1'b1);
		policy(24'h50094d, 1'b1, 1'b0, ADDR_CUSTOMER, 1'b0);
		policy(24'h50094d, 1'b0, 1'b0, ADDR_CUSTOMER, 1'b1);
		policy(24'hc1094d, 1'b1, 1'b0, ADDR_CUSTOMER_WORD_TWO, 1'b0);
		policy(24'hc1094d, 1'b1, 1'b0, ADDR_CUSTOMER, 1'b1);
		policy(24'hc1494d, 1'b1, 1'b0, ADDR_CUSTOMER, 1'b0);
		policy(24'h02094d, 1'b0, 1'b0, ADDR_CUSTOMER_WORD_TWO, 1'b0);
		policy(24'h02094d, 1'b0, 1'b0, ADDR_CUSTOMER, 1'b1);
		policy(24'h02494d, 1'b0, 1'b0, ADDR_CUSTOMER, 1'b0);
		policy(24'h00094d, 1'b0, 1'b0, ADDR_CUSTOMER_WORD_TWO, 1'b1);
		$display("test lock policy done");
		do_reset();
		flags(12'd1185, 1'b1, 1'b0);
		flags(12'd1184, 1'b0, 1'b0);
		flags(12'd207, 1'b0, 1'b1);
		flags(12'd208, 1'b0, 1'b0);
		wr(ADDR_COMMON, 32'h0);
		flags(12'd0, 1'b0, 1'b0);
		flags(12'hfff, 1'b0, 1'b0);
		$display("test field flags done");
		wr(ADDR_LIN_FIRST, 32'h00001ffe);
		wr(ADDR_LIN_LAST, 32'h00ff0010);
		lin(16'h0000, 1'b0, 16'h0004);
		lin(16'h0000, 1'b1, 16'h0008);
		lin(16'h0800, 1'b0, 16'h07fe);
		lin(16'hf000, 1'b0, 16'hefe0);
		lin(16'hf800, 1'b0, 16'hf820);
		lin(16'hf000, 1'b1, 16'hefc0);
		$display("test linearization done");
		for (n = 0; n <= 2; n += 2) begin
			lpm <= 6'(n);
			do_reset();
			host.access(1'b0, 1'b0, ADDR_ALIVE, 32'h0, q);
			a0 = q.rdata;
			check("alive_start", a0, 32'h0);
			repeat (50 * (n + 1) - 2) @(posedge sys_clk);
			host.access(1'b0, 1'b0, ADDR_ALIVE, 32'h0, q);
			check("alive_steps", q.rdata - a0, 32'h5);
		end
		lpm <= 6'h00;
		repeat (50) @(posedge sys_clk);
		host.command(CMD_HARD_RESET);
		check("hard_reset", 32'(hr_event), 32'h1);
		host.access(1'b0, 1'b0, ADDR_ALIVE, 32'h0, q);
		check("alive_cleared", 32'(q.rdata < 2), 32'h1);
		wr(ADDR_COMMON, 32'h0000194d);
		repeat (50) @(posedge sys_clk);
		host.command(CMD_HARD_RESET);
		check("hard_reset_off", 32'(hr_event), 32'h0);
		host.access(1'b0, 1'b0, ADDR_ALIVE, 32'h0, q);
		check("alive_kept", 32'(q.rdata >= 4), 32'h1);
		a0 = q.rdata;
		clk_en <= 1'b0;
		repeat (40) @(posedge sys_clk);
		clk_en <= 1'b1;
		host.access(1'b0, 1'b0, ADDR_ALIVE, 32'h0, q);
		check("alive_frozen", 32'(q.rdata - a0 < 2), 32'h1);
		$display("test alive done");
		do_reset();
		#1;
		check("no_powerup", {30'h0, running, bist_busy}, 32'h0);
		@(posedge sys_clk);
		fail_clear <= 1'b1;
		@(posedge sys_clk);
		fail_clear <= 1'b0;
		host.command(CMD_SELFTEST);
		check("st_start", {30'h0, running, done}, 32'h2);
		repeat (19) @(posedge sys_clk);
		#1;
		check("st_run", 32'(running), 32'h1);
		@(posedge sys_clk);
		#1;
		check("st_end", {29'h0, running, done, st_fail}, 32'h2);
		host.command(CMD_SELFTEST);
		@(posedge sys_clk);
		angle_ok <= 1'b0;
		@(posedge sys_clk);
		angle_ok <= 1'b1;
		repeat (20) @(posedge sys_clk);
		#1;
		check("st_fail", {29'h0, running, done, st_fail}, 32'h3);
		@(posedge sys_clk);
		fail_clear <= 1'b1;
		@(posedge sys_clk);
		fail_clear <= 1'b0;
		#1;
		check("st_clear", 32'(st_fail), 32'h0);
		wr(ADDR_COMMON, 32'h0000294d);
		host.command(CMD_SELFTEST);
		check("st_refused", 32'(running), 32'h0);
		wr(ADDR_COMMON, 32'h000c094d);
		host.command(CMD_HARD_RESET);
		repeat (2) @(posedge sys_clk);
		#1;
		check("powerup_tests", {30'h0, running, bist_busy}, 32'h3);
		repeat (18) @(posedge sys_clk);
		#1;
		check("bist_run", 32'(bist_busy), 32'h1);
		repeat (2) @(posedge sys_clk);
		#1;
		a0 = 32'(sig);
		check("bist_end", {30'h0, bist_busy, bist_fail}, {31'h0, sig != 31'h0});
		host.command(CMD_HARD_RESET);
		repeat (24) @(posedge sys_clk);
		#1;
		check("bist_repeat", 32'(sig), a0);
		$display("test self-test done");
		do_reset();
		repeat (2500) @(posedge sys_clk);
		#1;
		check("osc_ok", 32'(osc_fail), 32'h0);
		sleep_mode <= 1'b1;
		ref_run <= 1'b0;
		repeat (2500) @(posedge sys_clk);
		#1;
		check("osc_sleep", 32'(osc_fail), 32'h0);
		sleep_mode <= 1'b0;
		repeat (2500) @(posedge sys_clk);
		#1;
		check("osc_dead", 32'(osc_fail), 32'h1);
		$display("test watchdog done");
		end_of_test();
	end
endmodule
